// [design/aux_ctrl_pkg.sv]
// constants, types and register map of the aux interrupt / offset control bank
// assumes one clock domain and an AHB-Lite master with 32-bit word transfers
// Behaviour
// - data-ready latched at 0, pulsed at 1
// - merge bit copies line B events onto A
// - offset-on-output adds user offset to output data
// - offset-on-wake offsets wakeup data only
// - offset weight 977 ug or 15.6 mg
// - highpass reference mode follows its bit, default off
// - orientation fed half-rate or second lowpass data
// - per-axis offsets are signed eight-bit values
package aux_ctrl_pkg;

   // ==========================================================
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_FILTER_SCALE = 8'h25;
   localparam logic [7:0] IDX_OUT_X = 8'h28;
   localparam logic [7:0] IDX_OUT_Y = 8'h2A;
   localparam logic [7:0] IDX_OUT_Z = 8'h2C;
   localparam logic [7:0] IDX_X_OFFSET = 8'h3C;
   localparam logic [7:0] IDX_Y_OFFSET = 8'h3D;
   localparam logic [7:0] IDX_Z_OFFSET = 8'h3E;
   localparam logic [7:0] IDX_CONTROL = 8'h3F;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h41;

   // ==========================================================
   // field positions and reset values
   localparam int FILTER_PATH_BIT = 0;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] FILTER_RESET = 8'h00;
   localparam logic [7:0] OFFSET_RESET = 8'h00;
   localparam int STAT_READY = 0;
   localparam int STAT_SATURATE = 1;
   localparam int STAT_WIDTH = 2;
   localparam logic [STAT_WIDTH-1:0] STAT_RESET = 2'h0;

   // ==========================================================
   // offset weights, output data lsb is one light step
   localparam int OFFSET_W0_UG = 977;
   localparam int OFFSET_W1_UG = 15600;
   localparam int DATA_LSB_UG = 977;
   localparam int OFFSET_GAIN_W0 = (OFFSET_W0_UG + DATA_LSB_UG / 2) / DATA_LSB_UG;
   localparam int OFFSET_GAIN_W1 = (OFFSET_W1_UG + DATA_LSB_UG / 2) / DATA_LSB_UG;

   // ==========================================================
   // ahb-lite encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'h0;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic ready_pulse_select;
      logic second_line_merge;
      logic interrupts_enable;
      logic offset_on_output;
      logic offset_on_wake_detect;
      logic offset_weight_select;
      logic highpass_reference_select;
      logic orientation_lowpass_select;
   } control_t;

   typedef struct packed {
      logic signed [15:0] x;
      logic signed [15:0] y;
      logic signed [15:0] z;
   } axes_t;

   typedef struct packed {
      logic signed [7:0] x;
      logic signed [7:0] y;
      logic signed [7:0] z;
   } offsets_t;

endpackage : aux_ctrl_pkg

// [design/offset_apply.sv]
// adds weighted signed user offsets to three axes with saturation
// assumes inputs from logic on the same clock, purely combinational
module offset_apply
   import aux_ctrl_pkg::*;
(
   // data in
   input wire axes_t sample,
   input wire offsets_t offset,
   // settings
   input wire logic enable,
   input wire logic weight,
   // data out
   output axes_t result,
   output logic [2:0] saturated
);

   // ==========================================================
   // one axis: scale, add, clamp
   function automatic logic [16:0] apply_axis(input logic signed [15:0] s,
                                              input logic signed [7:0] o,
                                              input logic en,
                                              input logic w);
      logic signed [17:0] gain;
      logic signed [17:0] scaled;
      logic signed [17:0] sum;
      gain = w ? 18'(OFFSET_GAIN_W1) : 18'(OFFSET_GAIN_W0);
      scaled = en ? 18'(gain * 18'(o)) : 18'sh0;
      sum = 18'(s) + scaled;
      if (sum > 18'sh07FFF) begin
         apply_axis = {1'b1, 16'h7FFF};
      end else if (sum < -18'sh08000) begin
         apply_axis = {1'b1, 16'h8000};
      end else begin
         apply_axis = {1'b0, sum[15:0]};
      end
   endfunction : apply_axis

   logic [16:0] ax;
   logic [16:0] ay;
   logic [16:0] az;

   always_comb begin
      ax = apply_axis(sample.x, offset.x, enable, weight);
      ay = apply_axis(sample.y, offset.y, enable, weight);
      az = apply_axis(sample.z, offset.z, enable, weight);
      result = '{x: ax[15:0], y: ay[15:0], z: az[15:0]};
      saturated = {ax[16], ay[16], az[16]};
   end

endmodule : offset_apply

// [design/accel_aux_interrupt_offset_ctrl.sv]
// aux interrupt and user offset control bank with its data and line logic
// assumes an AHB-Lite master and sensor logic, all on CLK_SYS
//
// Chosen here: register access over AHB-Lite.
module accel_aux_interrupt_offset_ctrl
   import aux_ctrl_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [31:0] HRDATA,
   // sensor data in
   input wire logic SAMPLE_VALID,
   input wire axes_t SAMPLE,
   input wire axes_t ORIENT_HALF_ODR,
   input wire axes_t ORIENT_SECOND,
   // event functions routed to each line
   input wire logic LINE_A_EVENTS,
   input wire logic LINE_B_EVENTS,
   // data out
   output axes_t OUT_DATA,
   output axes_t WAKE_DATA,
   output axes_t ORIENT_DATA,
   // filter settings
   output logic HP_REF_ENABLE,
   output logic ORIENT_SECOND_SELECT,
   output logic FILTER_PATH_SELECT,
   // interrupt lines
   output logic INT_LINE_A,
   output logic INT_LINE_B,
   output logic IRQ
);

   // ==========================================================
   // state
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic wr_pend;
   logic [7:0] wr_idx;
   control_t control;
   logic [7:0] filter_scale_control;
   offsets_t user_offset;
   axes_t out_data;
   axes_t wake_data;
   axes_t orient_data;
   logic ready_latched;
   logic ready_pulse;
   logic line_a;
   logic line_b;
   logic [STAT_WIDTH-1:0] irq_status;
   logic [STAT_WIDTH-1:0] irq_mask;
   logic irq;

   logic next_wr_pend;
   logic [7:0] next_wr_idx;
   logic [31:0] next_hrdata;
   control_t next_control;
   logic [7:0] next_filter_scale_control;
   offsets_t next_user_offset;
   axes_t next_out_data;
   axes_t next_wake_data;
   axes_t next_orient_data;
   logic next_ready_latched;
   logic next_ready_pulse;
   logic next_line_a;
   logic next_line_b;
   logic [STAT_WIDTH-1:0] next_irq_status;
   logic [STAT_WIDTH-1:0] next_irq_mask;
   logic next_irq;

   logic take;
   logic addr_hit;
   logic [7:0] addr_idx;
   logic rd_take;
   logic serviced;
   logic ready_level;
   logic [STAT_WIDTH-1:0] stat_set;
   logic [STAT_WIDTH-1:0] stat_clr;
   axes_t out_adj;
   axes_t wake_adj;
   logic [2:0] out_sat;
   logic [2:0] wake_sat;

   // ==========================================================
   // bus slave: zero wait, always okay
   always_comb begin
      take = HSEL && HREADY && HTRANS[1] && (HSIZE == HSIZE_WORD);
      addr_hit = (HADDR[31:10] == 22'h0) && (HADDR[1:0] == 2'h0);
      addr_idx = HADDR[9:2];
      rd_take = take && !HWRITE && addr_hit;
      next_wr_pend = take && HWRITE && addr_hit;
      next_wr_idx = addr_idx;
      next_hrdata = 32'h0;
      if (rd_take) begin
         if (addr_idx == IDX_CONTROL) begin
            next_hrdata = {24'h0, next_control};
         end else if (addr_idx == IDX_FILTER_SCALE) begin
            next_hrdata = {24'h0, next_filter_scale_control};
         end else if (addr_idx == IDX_X_OFFSET) begin
            next_hrdata = {24'h0, next_user_offset.x};
         end else if (addr_idx == IDX_Y_OFFSET) begin
            next_hrdata = {24'h0, next_user_offset.y};
         end else if (addr_idx == IDX_Z_OFFSET) begin
            next_hrdata = {24'h0, next_user_offset.z};
         end else if (addr_idx == IDX_OUT_X) begin
            next_hrdata = {16'h0, out_data.x};
         end else if (addr_idx == IDX_OUT_Y) begin
            next_hrdata = {16'h0, out_data.y};
         end else if (addr_idx == IDX_OUT_Z) begin
            next_hrdata = {16'h0, out_data.z};
         end else if (addr_idx == IDX_IRQ_STATUS) begin
            next_hrdata = {30'h0, next_irq_status};
         end else if (addr_idx == IDX_IRQ_MASK) begin
            next_hrdata = {30'h0, next_irq_mask};
         end else begin
            next_hrdata = 32'h0;
         end
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         hreadyout <= 1'b0;
         hresp <= HRESP_OKAY;
         hrdata <= 32'h0;
         wr_pend <= 1'b0;
         wr_idx <= 8'h0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
         hrdata <= next_hrdata;
         wr_pend <= next_wr_pend;
         wr_idx <= next_wr_idx;
      end
   end

   // ==========================================================
   // configuration registers
   always_comb begin
      next_control = control;
      next_filter_scale_control = filter_scale_control;
      next_user_offset = user_offset;
      if (wr_pend) begin
         if (wr_idx == IDX_CONTROL) begin
            next_control = control_t'(HWDATA[7:0]);
         end else if (wr_idx == IDX_FILTER_SCALE) begin
            next_filter_scale_control = HWDATA[7:0];
         end else if (wr_idx == IDX_X_OFFSET) begin
            next_user_offset.x = HWDATA[7:0];
         end else if (wr_idx == IDX_Y_OFFSET) begin
            next_user_offset.y = HWDATA[7:0];
         end else if (wr_idx == IDX_Z_OFFSET) begin
            next_user_offset.z = HWDATA[7:0];
         end
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         control <= control_t'(CONTROL_RESET);
         filter_scale_control <= FILTER_RESET;
         user_offset <= offsets_t'({3{OFFSET_RESET}});
      end else begin
         control <= next_control;
         filter_scale_control <= next_filter_scale_control;
         user_offset <= next_user_offset;
      end
   end

   // ==========================================================
   // data paths: output, wakeup, orientation
   offset_apply out_path (
      .sample(SAMPLE),
      .offset(user_offset),
      .enable(control.offset_on_output),
      .weight(control.offset_weight_select),
      .result(out_adj),
      .saturated(out_sat)
   );

   offset_apply wake_path (
      .sample(SAMPLE),
      .offset(user_offset),
      .enable(control.offset_on_wake_detect || control.offset_on_output),
      .weight(control.offset_weight_select),
      .result(wake_adj),
      .saturated(wake_sat)
   );

   always_comb begin
      next_out_data = out_data;
      next_wake_data = wake_data;
      if (SAMPLE_VALID) begin
         next_out_data = out_adj;
         next_wake_data = wake_adj;
      end
      if (control.orientation_lowpass_select) begin
         next_orient_data = ORIENT_SECOND;
      end else begin
         next_orient_data = ORIENT_HALF_ODR;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         out_data <= '0;
         wake_data <= '0;
         orient_data <= '0;
      end else begin
         out_data <= next_out_data;
         wake_data <= next_wake_data;
         orient_data <= next_orient_data;
      end
   end

   // ==========================================================
   // data-ready, lines and sticky status
   always_comb begin
      serviced = rd_take && ((addr_idx == IDX_OUT_X) || (addr_idx == IDX_OUT_Y)
                             || (addr_idx == IDX_OUT_Z));
      next_ready_latched = !control.ready_pulse_select
                           && ((ready_latched && !serviced) || SAMPLE_VALID);
      next_ready_pulse = SAMPLE_VALID && control.ready_pulse_select;
      ready_level = control.ready_pulse_select ? ready_pulse : ready_latched;
      next_line_a = control.interrupts_enable && (ready_level || LINE_A_EVENTS
                    || (control.second_line_merge && LINE_B_EVENTS));
      next_line_b = control.interrupts_enable && LINE_B_EVENTS;
      stat_set = '0;
      stat_set[STAT_READY] = SAMPLE_VALID;
      stat_set[STAT_SATURATE] = SAMPLE_VALID && (|out_sat);
      stat_clr = '0;
      next_irq_mask = irq_mask;
      if (wr_pend && (wr_idx == IDX_IRQ_STATUS)) begin
         stat_clr = HWDATA[STAT_WIDTH-1:0];
      end
      if (wr_pend && (wr_idx == IDX_IRQ_MASK)) begin
         next_irq_mask = HWDATA[STAT_WIDTH-1:0];
      end
      next_irq_status = (irq_status & ~stat_clr) | stat_set;
      next_irq = |(next_irq_status & next_irq_mask);
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         ready_latched <= 1'b0;
         ready_pulse <= 1'b0;
         line_a <= 1'b0;
         line_b <= 1'b0;
         irq_status <= STAT_RESET;
         irq_mask <= STAT_RESET;
         irq <= 1'b0;
      end else begin
         ready_latched <= next_ready_latched;
         ready_pulse <= next_ready_pulse;
         line_a <= next_line_a;
         line_b <= next_line_b;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         irq <= next_irq;
      end
   end

   // ==========================================================
   // outputs
   assign HREADYOUT = hreadyout;
   assign HRESP = hresp;
   assign HRDATA = hrdata;
   assign OUT_DATA = out_data;
   assign WAKE_DATA = wake_data;
   assign ORIENT_DATA = orient_data;
   assign HP_REF_ENABLE = control.highpass_reference_select;
   assign ORIENT_SECOND_SELECT = control.orientation_lowpass_select;
   assign FILTER_PATH_SELECT = filter_scale_control[FILTER_PATH_BIT];
   assign INT_LINE_A = line_a;
   assign INT_LINE_B = line_b;
   assign IRQ = irq;

   // ==========================================================
   // checks
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);

   logic wr_ctrl;
   assign wr_ctrl = wr_pend && (wr_idx == IDX_CONTROL);

   ready_latch_hold_a: assert property (
      (ready_latched && !control.ready_pulse_select && control.interrupts_enable
       && !serviced && !wr_ctrl) ##1 !serviced |=> INT_LINE_A)
      else $error("latched data-ready not held on line A");

   ready_pulse_a: assert property (
      (SAMPLE_VALID && control.ready_pulse_select && !wr_ctrl) ##1 !SAMPLE_VALID
      |=> ready_pulse == 1'b0 && $past(ready_pulse) && !ready_latched)
      else $error("pulsed data-ready not one cycle");

   merge_route_a: assert property (
      (control.second_line_merge && control.interrupts_enable && LINE_B_EVENTS)
      |=> INT_LINE_A && INT_LINE_B)
      else $error("line B event missing on line A");

   offset_out_a: assert property (
      (SAMPLE_VALID && control.offset_on_output && !control.offset_weight_select
       && !out_sat[2])
      |=> OUT_DATA.x == $past(SAMPLE.x) + {{8{$past(user_offset.x[7])}}, $past(user_offset.x)})
      else $error("output offset not added on x");

   wake_only_a: assert property (
      (SAMPLE_VALID && !control.offset_on_output) |=> OUT_DATA == $past(SAMPLE))
      else $error("output data touched without offset-on-output");

   weight_a: assert property (
      (SAMPLE_VALID && control.offset_on_wake_detect && control.offset_weight_select
       && !wake_sat[0])
      |=> WAKE_DATA.z == $past(SAMPLE.z) + 16'({{8{$past(user_offset.z[7])}},
                                                 $past(user_offset.z)} * 16'h10))
      else $error("heavy offset weight wrong on z");

   sign_a: assert property (
      (SAMPLE_VALID && control.offset_on_output && user_offset.y[7] && !out_sat[1])
      |=> OUT_DATA.y < $past(SAMPLE.y))
      else $error("negative offset did not lower y");

   hp_ref_a: assert property (
      wr_ctrl |=> HP_REF_ENABLE == $past(HWDATA[1]))
      else $error("highpass reference not following control");

   orient_a: assert property (
      !control.orientation_lowpass_select |=> ORIENT_DATA == $past(ORIENT_HALF_ODR))
      else $error("orientation not fed half-rate data");

   irq_gate_a: assert property (
      !control.interrupts_enable |=> !INT_LINE_A && !INT_LINE_B)
      else $error("line asserted while interrupts disabled");

   layout_a: assert property (
      wr_ctrl |=> control.ready_pulse_select == $past(HWDATA[7])
                  && control.orientation_lowpass_select == $past(HWDATA[0]))
      else $error("control bit order wrong");

   pulse_c: cover property (SAMPLE_VALID && control.ready_pulse_select ##2 INT_LINE_A);
   merge_c: cover property (control.second_line_merge && LINE_B_EVENTS ##1 INT_LINE_A);
   sat_c: cover property (irq_status[STAT_SATURATE] ##1 IRQ);
   service_c: cover property (ready_latched && serviced ##1 !ready_latched);

endmodule : accel_aux_interrupt_offset_ctrl

// [verification/sensor_source.sv]
// partner model: sensor logic feeding samples, orientation data and event lines
// assumes the block's clock; tasks are called by the testbench
module sensor_source
   import aux_ctrl_pkg::*;
(
   // clock
   input wire logic clk,
   // sample path
   output logic sample_valid,
   output axes_t sample,
   // orientation data and event lines
   output axes_t orient_half,
   output axes_t orient_second,
   output logic events_a,
   output logic events_b
);
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================
   // idle state
   initial begin
      sample_valid = 1'b0;
      sample = '0;
      orient_half = '0;
      orient_second = '0;
      events_a = 1'b0;
      events_b = 1'b0;
   end

   // ==========================================================
   // one-cycle strobe, data no longer held once it drops
   task automatic send(input axes_t s);
      @(posedge clk);
      sample_valid <= 1'b1;
      sample <= s;
      @(posedge clk);
      sample_valid <= 1'b0;
      sample <= ~s;
   endtask : send

   // ==========================================================
   // level inputs
   task automatic set_lines(input axes_t h, input axes_t q, input logic a, input logic b);
      @(posedge clk);
      orient_half <= h;
      orient_second <= q;
      events_a <= a;
      events_b <= b;
   endtask : set_lines
endmodule : sensor_source

// [verification/testbench.sv]
// self-checking bench: ahb-lite register tasks and sensor partner model
// assumes zero-wait slave as handed over, 10 MHz clock, active-high reset
module testbench
   import aux_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================
   // signals
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] hwdata = '0;
   logic hreadyout, hresp, int_line_a, int_line_b, irq;
   logic hp_ref_enable, orient_second_select, filter_path_select, sample_valid;
   logic [31:0] hrdata, rd;
   logic events_a, events_b;
   axes_t sample, orient_half, orient_second, out_data, wake_data, orient_data, s;
   offsets_t ofs;
   logic [7:0] ctl [5] = '{8'h00, 8'h10, 8'h08, 8'h0C, 8'h14};
   int errors = 0;
   int checked = 0;
   int cnt;

   always #50 clk_sys = ~clk_sys;

   sensor_source src (.clk(clk_sys), .sample_valid(sample_valid), .sample(sample),
      .orient_half(orient_half), .orient_second(orient_second),
      .events_a(events_a), .events_b(events_b));

   accel_aux_interrupt_offset_ctrl dut (.CLK_SYS(clk_sys), .RST(rst), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata),
      .SAMPLE_VALID(sample_valid), .SAMPLE(sample), .ORIENT_HALF_ODR(orient_half),
      .ORIENT_SECOND(orient_second), .LINE_A_EVENTS(events_a), .LINE_B_EVENTS(events_b),
      .OUT_DATA(out_data), .WAKE_DATA(wake_data), .ORIENT_DATA(orient_data),
      .HP_REF_ENABLE(hp_ref_enable), .ORIENT_SECOND_SELECT(orient_second_select),
      .FILTER_PATH_SELECT(filter_path_select), .INT_LINE_A(int_line_a),
      .INT_LINE_B(int_line_b), .IRQ(irq));

   // ==========================================================
   // helpers
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #10;
   endtask : tick

   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) errors++;
   endtask : wait_ready

   task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= HSIZE_WORD;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      bus(idx, 1'b1, d);
   endtask : wr

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      bus(idx, 1'b0, 32'h0);
      check({15'h0, hresp, rd}, {15'h0, HRESP_OKAY, exp});
   endtask : rdchk

   function automatic logic [15:0] sat(input int v);
      return v > 32767 ? 16'h7FFF : (v < -32768 ? 16'h8000 : 16'(v));
   endfunction : sat

   function automatic axes_t adj(input axes_t a, input offsets_t o, input logic w);
      axes_t r;
      int m;
      m = w ? 16 : 1;
      r.x = sat(a.x + o.x * m);
      r.y = sat(a.y + o.y * m);
      r.z = sat(a.z + o.z * m);
      return r;
   endfunction : adj

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   // ==========================================================
   // watchdog
   initial begin
      #2000000;
      errors++;
      test_done();
   end

   // ==========================================================
   // tests
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rdchk(IDX_CONTROL, 32'h0);
      rdchk(IDX_X_OFFSET, 32'h0);
      rdchk(IDX_IRQ_MASK, 32'h0);
      wr(8'h3B, 32'hFF);
      rdchk(8'h3B, 32'h0);
      for (int i = 0; i < 8; i++) begin
         wr(IDX_CONTROL, 32'h1 << i);
         rdchk(IDX_CONTROL, 32'h1 << i);
         tick(1);
         check({46'h0, hp_ref_enable, orient_second_select}, (48'h1 << i) & 48'h3);
      end
      $display("test control_bits done");
      src.set_lines(48'h0001_0002_0003, 48'hFFF1_FFF2_FFF3, 1'b0, 1'b0);
      wr(IDX_CONTROL, 32'h00);
      tick(2);
      check(orient_data, 48'h0001_0002_0003);
      wr(IDX_CONTROL, 32'h01);
      tick(2);
      check(orient_data, 48'hFFF1_FFF2_FFF3);
      $display("test orientation done");
      wr(IDX_FILTER_SCALE, 32'h1);
      tick(1);
      check({47'h0, filter_path_select}, 48'h1);
      wr(IDX_FILTER_SCALE, 32'h0);
      ofs = 24'h05_FD_7F;
      wr(IDX_X_OFFSET, 32'h05);
      wr(IDX_Y_OFFSET, 32'hFD);
      wr(IDX_Z_OFFSET, 32'h7F);
      rdchk(IDX_Y_OFFSET, 32'hFD);
      s = 48'h0064_00C8_FFCE;
      for (int i = 0; i < 5; i++) begin
         wr(IDX_CONTROL, {24'h0, ctl[i]});
         src.send(s);
         tick(1);
         check(out_data, ctl[i][4] ? adj(s, ofs, ctl[i][2]) : s);
         check(wake_data, |ctl[i][4:3] ? adj(s, ofs, ctl[i][2]) : s);
      end
      $display("test offsets done");
      wr(IDX_IRQ_STATUS, 32'h3);
      rdchk(IDX_IRQ_STATUS, 32'h0);
      s = 48'h7FF0_0000_0000;
      src.send(s);
      tick(2);
      check(out_data, adj(s, ofs, 1'b1));
      check({47'h0, irq}, 48'h0);
      rdchk(IDX_IRQ_STATUS, 32'h3);
      wr(IDX_IRQ_MASK, 32'h1);
      tick(1);
      check({47'h0, irq}, 48'h1);
      wr(IDX_IRQ_STATUS, 32'h3);
      tick(1);
      check({47'h0, irq}, 48'h0);
      $display("test status_irq done");
      rdchk(IDX_OUT_Z, 32'h07F0);
      wr(IDX_CONTROL, 32'h20);
      tick(1);
      check({47'h0, int_line_a}, 48'h0);
      s = 48'h0123_0456_0789;
      src.send(s);
      tick(2);
      check({47'h0, int_line_a}, 48'h1);
      rdchk(IDX_OUT_X, 32'h0123);
      tick(2);
      check({47'h0, int_line_a}, 48'h0);
      wr(IDX_CONTROL, 32'hA0);
      src.send(s);
      cnt = 0;
      repeat (6) begin
         tick(1);
         if (int_line_a === 1'b1) cnt++;
      end
      check(48'(cnt), 48'h1);
      $display("test data_ready done");
      src.set_lines(48'h0, 48'h0, 1'b1, 1'b1);
      wr(IDX_CONTROL, 32'hC0);
      tick(2);
      check({46'h0, int_line_a, int_line_b}, 48'h0);
      src.set_lines(48'h0, 48'h0, 1'b0, 1'b1);
      wr(IDX_CONTROL, 32'hA0);
      tick(2);
      check({46'h0, int_line_a, int_line_b}, 48'h1);
      wr(IDX_CONTROL, 32'hE0);
      tick(2);
      check({46'h0, int_line_a, int_line_b}, 48'h3);
      src.set_lines(48'h0, 48'h0, 1'b1, 1'b0);
      wr(IDX_CONTROL, 32'hA0);
      tick(2);
      check({46'h0, int_line_a, int_line_b}, 48'h2);
      $display("test lines done");
      test_done();
   end
endmodule : testbench
